// File: design/btc_bus_trace_capture.sv
// Bus trace capture: latches each monitored bus cycle, filters it through
// qualification masks, stores it with a time stamp in a 4K ring and stops
// on a trigger. Bus and management signals are synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none

module btc_bus_trace_capture
  import btc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Control and status
  input  wire logic [15:0]          ctrl_word_i,
  input  wire logic                 start_i,
  input  wire logic                 abort_i,
  input  wire logic [AW-1:0]        post_count_i,
  input  wire btc_pkg::btc_cond_t   qual_cond_i [NCOND],
  input  wire btc_pkg::btc_cond_t   trig_cond_i [NCOND],
  output logic [7:0]                status_word_o,
  output logic [AW-1:0]             wr_addr_o,
  // Monitored system bus
  input  wire logic [23:0]          bus_addr_i,
  input  wire logic                 bus_addr_valid_i,
  input  wire logic [15:0]          bus_data_i,
  input  wire logic                 bus_data_valid_i,
  input  wire logic                 bus_write_i,
  input  wire logic                 io_transfer_cycle_i,
  input  wire logic                 bus_cycle_end_i,
  // Memory-management bus
  input  wire logic [3:0]           memory_mgmt_bus_cmd_i,
  input  wire btc_pkg::btc_mmb_t    memory_mgmt_bus_i,
  // Host processor
  input  wire logic                 host_stopped_i,
  output logic                      host_halt_o,
  // Embedded processor word access
  input  wire logic                 acc_req_i,
  input  wire logic                 acc_write_i,
  input  wire logic [AW-1:0]        acc_addr_i,
  input  wire logic [2:0]           acc_word_i,
  input  wire logic [15:0]          acc_wdata_i,
  output logic                      acc_ack_o,
  output logic [15:0]               acc_rdata_o
);
  import btc_pkg::*;

  // ----------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN  = 4'h2,
    ST_POST = 4'h4,
    ST_DONE = 4'h8
  } btc_state_t;

  // Physical mode ignores logical page and table, logical mode ignores the
  // physical address; the bank sits in the top bits of the physical address.
  function automatic logic cond_hit(input btc_entry_t e, input btc_cond_t c);
    btc_entry_t care;
    care = c.care;
    if (c.logical_mode) begin
      care.phys_addr = 24'h000000;
    end else begin
      care.logical_page = 6'h00;
      care.page_table   = 4'h0;
    end
    return ((e ^ c.value) & care) == '0;
  endfunction

  function automatic logic any_hit(input btc_entry_t e, input btc_cond_t c [NCOND],
                                   input logic [NCOND-1:0] en);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NCOND; i++) begin
      hit = hit | (en[i] & cond_hit(e, c[i]));
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------------
  // Control word decode
  // ----------------------------------------------------------------------
  logic             bus_en;
  logic             halt_en;
  logic             trig_on_stop;
  logic             stop_now;
  logic             seq_en;
  logic             seq_qual_only;
  logic [1:0]       seq_len;
  logic [NCOND-1:0] qual_en;
  logic [NCOND-1:0] trig_en;

  assign bus_en        = ctrl_word_i[CW_BUS_EN];
  assign halt_en       = ctrl_word_i[CW_HALT_EN];
  assign trig_on_stop  = ctrl_word_i[CW_TRIG_STOP];
  assign stop_now      = ctrl_word_i[CW_STOP_NOW];
  assign seq_en        = ctrl_word_i[CW_SEQ_EN];
  assign seq_qual_only = ctrl_word_i[CW_SEQ_QUAL];
  assign seq_len       = ctrl_word_i[CW_SEQ_LEN +: 2];
  assign qual_en       = ctrl_word_i[CW_QUAL_EN +: NCOND];
  assign trig_en       = ctrl_word_i[CW_TRIG_EN +: NCOND];

  // ----------------------------------------------------------------------
  // Cycle latches
  // ----------------------------------------------------------------------
  logic [23:0] addr_q;
  logic [15:0] data_q;
  btc_mmb_t    mmb_q;
  btc_state_t  state_q;
  logic        capturing;

  assign capturing = (state_q == ST_RUN) || (state_q == ST_POST);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 24'h000000;
      data_q <= 16'h0000;
    end else if (ce_i && capturing && bus_en) begin
      if (bus_addr_valid_i) begin
        addr_q <= bus_addr_i;
      end
      if (bus_data_valid_i) begin
        data_q <= bus_data_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mmb_q <= '0;
    end else if (ce_i && memory_mgmt_bus_cmd_i == MMB_LATCH_CODE) begin
      mmb_q <= memory_mgmt_bus_i;
    end
  end

  // Entry assembled at cycle end; write and I/O flags come live with the end.
  btc_entry_t entry;
  always_comb begin
    entry                    = '0;
    entry.data               = data_q;
    entry.phys_addr          = addr_q;
    entry.logical_page       = mmb_q.logical_page;
    entry.page_table         = mmb_q.page_table;
    entry.level              = mmb_q.level;
    entry.paging_on_flag     = mmb_q.paging_on_flag;
    entry.interrupts_on_flag = mmb_q.interrupts_on_flag;
    entry.alt_table          = mmb_q.alt_table;
    entry.instr_fetch        = mmb_q.instr_fetch;
    entry.cpu_access         = mmb_q.cpu_access;
    entry.write              = bus_write_i;
    entry.io_transfer_cycle  = io_transfer_cycle_i;
  end

  // ----------------------------------------------------------------------
  // Qualification and trigger detection
  // ----------------------------------------------------------------------
  logic cycle_seen;
  logic qualified;
  logic trig_hit;
  logic seq_fire;
  logic trig_fire;
  logic [2:0] seq_cnt_q;

  assign cycle_seen = capturing && bus_en && bus_cycle_end_i;
  // With no qualifier enabled every cycle is kept.
  assign qualified  = cycle_seen &&
                      ((qual_en == '0) || any_hit(entry, qual_cond_i, qual_en));
  assign trig_hit   = any_hit(entry, trig_cond_i, trig_en);

  // Sequence counter: consecutive events matching any trigger word.
  logic seq_step;
  assign seq_step = seq_qual_only ? qualified : cycle_seen;
  assign seq_fire = seq_step && trig_hit && (seq_cnt_q == {1'b0, seq_len});

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      seq_cnt_q <= 3'h0;
    end else if (ce_i) begin
      if (start_i || !seq_en) begin
        seq_cnt_q <= 3'h0;
      end else if (seq_step) begin
        seq_cnt_q <= (trig_hit && !seq_fire) ? seq_cnt_q + 3'h1 : 3'h0;
      end
    end
  end

  // Host stop counts as a trigger only when the option is set.
  assign trig_fire = (state_q == ST_RUN) &&
                     ((seq_en ? seq_fire : (cycle_seen && trig_hit)) ||
                      (trig_on_stop && host_stopped_i));

  // ----------------------------------------------------------------------
  // Stop control
  // ----------------------------------------------------------------------
  logic [AW-1:0] post_q;
  logic          trig_seen_q;
  logic          store;

  // With stop-now set, the trigger cycle itself is not written.
  assign store = qualified && !(trig_fire && stop_now);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      post_q      <= 12'h000;
      trig_seen_q <= 1'b0;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE, ST_DONE: begin
          if (start_i) begin
            state_q     <= ST_RUN;
            trig_seen_q <= 1'b0;
          end
        end
        ST_RUN: begin
          if (abort_i) begin
            state_q <= ST_DONE;
          end else if (trig_fire) begin
            trig_seen_q <= 1'b1;
            post_q      <= post_count_i;
            state_q     <= (stop_now || post_count_i == 12'h000) ? ST_DONE : ST_POST;
          end
        end
        ST_POST: begin
          if (abort_i || (qualified && post_q == 12'h001)) begin
            state_q <= ST_DONE;
          end else if (qualified) begin
            post_q <= post_q - 12'h001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Halt request holds until the next start.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_halt_o <= 1'b0;
    end else if (ce_i) begin
      if (start_i && !capturing) begin
        host_halt_o <= 1'b0;
      end else if (trig_fire && halt_en) begin
        host_halt_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------------
  // Value counts 1 us units in unit 0 and 1000 us units in units 1 to 3; after 1000 units the unit field steps up in units 0 to 2; unit 3 saturates.
  // Coarse units lose accuracy on small figures; this is the intent.
  logic [7:0]  pre_q;
  logic [9:0]  sub_q;
  logic [1:0]  unit_q;
  logic [13:0] tval_q;
  logic        us_tick;

  assign us_tick = (pre_q == US_CYCLES - 8'h01);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q  <= 8'h00;
      sub_q  <= 10'h000;
      unit_q <= 2'h0;
      tval_q <= 14'h0000;
    end else if (ce_i) begin
      if (qualified || start_i) begin
        pre_q  <= 8'h00;
        sub_q  <= 10'h000;
        unit_q <= 2'h0;
        tval_q <= 14'h0000;
      end else begin
        pre_q <= us_tick ? 8'h00 : pre_q + 8'h01;
        if (us_tick) begin
          if (unit_q == 2'h0) begin
            if (tval_q == {4'h0, UNIT_SPAN}) begin
              unit_q <= 2'h1;
              tval_q <= 14'h0001;
            end else begin
              tval_q <= tval_q + 14'h0001;
            end
          end else if (sub_q == UNIT_SPAN - 10'h001) begin
            sub_q <= 10'h000;
            if (tval_q == {4'h0, UNIT_SPAN} && unit_q != UNIT_LAST) begin
              unit_q <= unit_q + 2'h1;
              tval_q <= 14'h0001;
            end else if (tval_q != TIMER_MAX) begin
              tval_q <= tval_q + 14'h0001;
            end
          end else begin
            sub_q <= sub_q + 10'h001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trace memory and ring pointer
  // ----------------------------------------------------------------------
  logic [WW-1:0] mem [WORDS][DEPTH];
  logic [AW-1:0] wr_q;
  logic          wrap_q;
  logic [WW-1:0] time_word;

  assign time_word = {unit_q, tval_q};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q   <= 12'h000;
      wrap_q <= 1'b0;
    end else if (ce_i) begin
      if (start_i && !capturing) begin
        wr_q   <= 12'h000;
        wrap_q <= 1'b0;
      end else if (store) begin
        wr_q <= wr_q + 12'h001;
        if (wr_q == LAST_ADDR) begin
          wrap_q <= 1'b1;
        end
      end
    end
  end

  // Capture has the write port; processor access waits while capturing.
  assign acc_ack_o = acc_req_i && !capturing;

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (store) begin
        mem[0][wr_q] <= entry[15:0];
        mem[1][wr_q] <= entry[31:16];
        mem[2][wr_q] <= entry[47:32];
        mem[3][wr_q] <= {3'h0, entry[60:48]};
        mem[4][wr_q] <= time_word;
      end else if (acc_ack_o && acc_write_i && acc_word_i <= LAST_WORD) begin
        mem[acc_word_i][acc_addr_i] <= acc_wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      acc_rdata_o <= 16'h0000;
    end else if (ce_i && acc_ack_o && !acc_write_i) begin
      acc_rdata_o <= (acc_word_i <= LAST_WORD) ? mem[acc_word_i][acc_addr_i] : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  always_comb begin
    status_word_o                     = 8'h00;
    status_word_o[SW_RUN]             = capturing;
    status_word_o[SW_POST]            = (state_q == ST_POST);
    status_word_o[SW_DONE]            = (state_q == ST_DONE);
    status_word_o[SW_TRIG]            = trig_seen_q;
    status_word_o[SW_WRAP]            = wrap_q;
    status_word_o[SW_HALT]            = host_halt_o;
    status_word_o[SW_UNIT +: 2]       = unit_q;
  end

  assign wr_addr_o = wr_q;

endmodule : btc_bus_trace_capture

`default_nettype wire

// File: shared/btc_pkg.sv
// Constants, field layouts and carrier types for the bus trace capture unit.
// Assumes a single 125 MHz clock; all bus inputs arrive synchronous to it.
package btc_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DEPTH      = 4096;
  localparam int unsigned AW         = 12;
  localparam int unsigned WORDS      = 5;
  localparam int unsigned WW         = 16;
  localparam int unsigned NCOND      = 4;
  localparam logic [2:0]  LAST_WORD  = 3'h4;
  localparam logic [AW-1:0] LAST_ADDR = 12'hFFF;

  // ----------------------------------------------------------------------
  // Control word bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned CW_BUS_EN     = 0;
  localparam int unsigned CW_HALT_EN    = 1;
  localparam int unsigned CW_TRIG_STOP  = 2;
  localparam int unsigned CW_STOP_NOW   = 3;
  localparam int unsigned CW_SEQ_EN     = 4;
  localparam int unsigned CW_SEQ_QUAL   = 5;
  localparam int unsigned CW_SEQ_LEN    = 6;   // two bits: events minus one
  localparam int unsigned CW_QUAL_EN    = 8;   // four bits
  localparam int unsigned CW_TRIG_EN    = 12;  // four bits

  // Status word bit positions
  localparam int unsigned SW_RUN     = 0;
  localparam int unsigned SW_POST    = 1;
  localparam int unsigned SW_DONE    = 2;
  localparam int unsigned SW_TRIG    = 3;
  localparam int unsigned SW_WRAP    = 4;
  localparam int unsigned SW_HALT    = 5;
  localparam int unsigned SW_UNIT    = 6;      // two bits

  // ----------------------------------------------------------------------
  // Memory-management bus strobe and timer
  // ----------------------------------------------------------------------
  localparam logic [3:0]  MMB_LATCH_CODE = 4'h5;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned US_NS          = 1000;
  localparam int unsigned CLK_NS         = 1000 / CLK_MHZ;
  localparam logic [7:0]  US_CYCLES      = 8'(US_NS / CLK_NS);
  localparam logic [9:0]  UNIT_SPAN      = 10'h3E8;    // 1000 units per step
  localparam logic [13:0] TIMER_MAX      = 14'h3FFF;
  localparam logic [1:0]  UNIT_LAST      = 2'h3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        paging_on_flag;
    logic        interrupts_on_flag;
    logic        alt_table;
    logic        instr_fetch;
    logic        cpu_access;
    logic        write;
    logic        io_transfer_cycle;
    logic [3:0]  level;
    logic [3:0]  page_table;
    logic [5:0]  logical_page;
    logic [23:0] phys_addr;
    logic [15:0] data;
  } btc_entry_t;                                 // 61 bits, time word apart

  typedef struct packed {
    logic        logical_mode;
    btc_entry_t  value;
    btc_entry_t  care;
  } btc_cond_t;

  typedef struct packed {
    logic        paging_on_flag;
    logic        interrupts_on_flag;
    logic        alt_table;
    logic        instr_fetch;
    logic        cpu_access;
    logic [3:0]  level;
    logic [3:0]  page_table;
    logic [5:0]  logical_page;
  } btc_mmb_t;

endpackage : btc_pkg

// File: dv/btc_bus_model.sv
// Model of the monitored system bus and memory-management bus.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
`default_nettype none

module btc_bus_model
  import btc_pkg::*;
(
  // Clock
  input  wire logic          clock_i,
  // System bus
  output logic [23:0]        bus_addr_o,
  output logic               bus_addr_valid_o,
  output logic [15:0]        bus_data_o,
  output logic               bus_data_valid_o,
  output logic               bus_write_o,
  output logic               io_cycle_o,
  output logic               cycle_end_o,
  // Memory-management bus
  output logic [3:0]         mmb_cmd_o,
  output btc_pkg::btc_mmb_t  mmb_o
);
  initial begin
    {bus_addr_o, bus_addr_valid_o, bus_data_o, bus_data_valid_o} = '0;
    {bus_write_o, io_cycle_o, cycle_end_o, mmb_cmd_o, mmb_o} = '0;
  end

  // --------------------------------------------------------------
  // Bus cycle: address, then data, then end; released lines invert
  // so a late sample never sees the old value
  // --------------------------------------------------------------
  task automatic cycle(input logic [23:0] a, input logic [15:0] d,
                       input logic w, input logic io);
    @(posedge clock_i);
    bus_addr_o       <= a;
    bus_addr_valid_o <= 1'b1;
    @(posedge clock_i);
    bus_addr_valid_o <= 1'b0;
    bus_addr_o       <= ~a;
    bus_data_o       <= d;
    bus_data_valid_o <= 1'b1;
    @(posedge clock_i);
    bus_data_valid_o <= 1'b0;
    bus_data_o       <= ~d;
    bus_write_o      <= w;
    io_cycle_o       <= io;
    cycle_end_o      <= 1'b1;
    @(posedge clock_i);
    cycle_end_o      <= 1'b0;
    bus_write_o      <= ~w;
    io_cycle_o       <= ~io;
  endtask

  task automatic mmb_set(input btc_mmb_t m);
    @(posedge clock_i);
    mmb_cmd_o <= MMB_LATCH_CODE;
    mmb_o     <= m;
    @(posedge clock_i);
    mmb_cmd_o <= ~MMB_LATCH_CODE;
    mmb_o     <= ~m;
  endtask
endmodule // btc_bus_model

`default_nettype wire

// File: dv/btc_bus_trace_capture_assertions.sv
// Port checker for the bus trace capture unit.
// Assumes one clock; bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module btc_bus_trace_capture_assertions
  import btc_pkg::*;
(
  // Watched ports
  input wire logic          clock_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  input wire logic [15:0]   ctrl_word_i,
  input wire logic          start_i,
  input wire logic          abort_i,
  input wire logic [7:0]    status_word_o,
  input wire logic [AW-1:0] wr_addr_o,
  input wire logic          bus_cycle_end_i,
  input wire logic          host_stopped_i,
  input wire logic          host_halt_o,
  input wire logic          acc_req_i,
  input wire logic          acc_ack_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic busy;
  assign busy = status_word_o[SW_RUN] || status_word_o[SW_POST];

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  chk_ack_busy: assert property (acc_req_i |-> acc_ack_o == !busy)
    else $error("access acknowledge wrong for capture state");
  chk_idle_hold: assert property (!busy && !start_i |=> $stable(wr_addr_o))
    else $error("write address moved while idle");
  chk_end_hold: assert property (busy && !bus_cycle_end_i |=> $stable(wr_addr_o))
    else $error("write address moved without a bus cycle");
  chk_step_one: assert property ($changed(wr_addr_o) |->
    wr_addr_o == AW'($past(wr_addr_o) + 1) || $past(start_i))
    else $error("write address did not step by one");
  chk_all_qual: assert property (busy && ctrl_word_i[15:8] == 8'h00 && ctrl_word_i[0]
    && !ctrl_word_i[2] && bus_cycle_end_i && ce_i && !abort_i
    |=> wr_addr_o == AW'($past(wr_addr_o) + 1))
    else $error("cycle not stored with no qualifier enabled");
  chk_halt_cause: assert property ($rose(host_halt_o) |->
    status_word_o[SW_TRIG] && ctrl_word_i[CW_HALT_EN])
    else $error("halt raised without trigger and enable");
  chk_halt_holds: assert property (host_halt_o && !start_i |=> host_halt_o)
    else $error("halt dropped before next start");
  chk_abort_ends: assert property (busy && abort_i && ce_i |=>
    status_word_o[SW_DONE] && !busy)
    else $error("abort did not end capture");
  chk_host_trig: assert property (busy && ctrl_word_i[CW_TRIG_STOP] && host_stopped_i
    && ce_i && !abort_i |-> ##[1:2] status_word_o[SW_TRIG])
    else $error("host stop did not trigger");
  chk_start_clear: assert property (start_i && ce_i && !busy && !abort_i |=>
    busy && wr_addr_o == '0 && !host_halt_o)
    else $error("start did not begin a clean capture");

  cov_wrap: cover property (wr_addr_o == LAST_ADDR ##1 wr_addr_o == '0);
  cov_halt: cover property ($rose(host_halt_o));
  cov_trig: cover property ($rose(status_word_o[SW_TRIG]));
endmodule // btc_bus_trace_capture_assertions

bind btc_bus_trace_capture btc_bus_trace_capture_assertions chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .ctrl_word_i(ctrl_word_i),
  .start_i(start_i), .abort_i(abort_i), .status_word_o(status_word_o),
  .wr_addr_o(wr_addr_o), .bus_cycle_end_i(bus_cycle_end_i),
  .host_stopped_i(host_stopped_i), .host_halt_o(host_halt_o),
  .acc_req_i(acc_req_i), .acc_ack_o(acc_ack_o));

`default_nettype wire

// File: dv/tb_bus_trace_capture.sv
// Self-checking bench for the bus trace capture unit.
// Assumes the bus model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none

module tb_bus_trace_capture;
  import btc_pkg::*;
  logic          clock_i, rst_i, start_i, abort_i, host_stopped_i, host_halt_o;
  logic          acc_req_i, acc_write_i, acc_ack_o, b_av, b_dv, b_wr, b_io, b_end;
  logic [15:0]   ctrl_word_i, acc_wdata_i, acc_rdata_o, v, b_data;
  logic [AW-1:0] post_count_i, wr_addr_o, acc_addr_i;
  logic [2:0]    acc_word_i;
  logic [7:0]    status_word_o;
  logic [23:0]   b_addr;
  logic [3:0]    m_cmd;
  logic [63:0]   ex;
  btc_mmb_t      m_bus;
  btc_cond_t     qc [NCOND];
  btc_cond_t     tc [NCOND];
  int            fail_count, compares;

  btc_bus_model bus_u (.clock_i(clock_i), .bus_addr_o(b_addr), .bus_addr_valid_o(b_av),
    .bus_data_o(b_data), .bus_data_valid_o(b_dv), .bus_write_o(b_wr), .io_cycle_o(b_io),
    .cycle_end_o(b_end), .mmb_cmd_o(m_cmd), .mmb_o(m_bus));
  btc_bus_trace_capture dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .ctrl_word_i(ctrl_word_i), .start_i(start_i), .abort_i(abort_i),
    .post_count_i(post_count_i), .qual_cond_i(qc), .trig_cond_i(tc),
    .status_word_o(status_word_o), .wr_addr_o(wr_addr_o), .bus_addr_i(b_addr),
    .bus_addr_valid_i(b_av), .bus_data_i(b_data), .bus_data_valid_i(b_dv),
    .bus_write_i(b_wr), .io_transfer_cycle_i(b_io), .bus_cycle_end_i(b_end),
    .memory_mgmt_bus_cmd_i(m_cmd), .memory_mgmt_bus_i(m_bus),
    .host_stopped_i(host_stopped_i), .host_halt_o(host_halt_o), .acc_req_i(acc_req_i),
    .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i), .acc_word_i(acc_word_i),
    .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o), .acc_rdata_o(acc_rdata_o));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic results;
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic go(input logic [15:0] cw);
    @(posedge clock_i);
    ctrl_word_i <= cw;
    start_i     <= 1'b1;
    @(posedge clock_i);
    start_i     <= 1'b0;
  endtask
  task automatic stop_run;
    @(posedge clock_i);
    abort_i <= 1'b1;
    @(posedge clock_i);
    abort_i <= 1'b0;
    tick(1);
    chk(status_word_o[SW_DONE], 1'b1);
  endtask
  // Word access; the acknowledge is judged at the edge that takes it
  task automatic acc(input logic w, input logic [11:0] a, input logic [2:0] k,
                     input logic [15:0] d, input logic ack);
    @(posedge clock_i);
    {acc_req_i, acc_write_i, acc_addr_i, acc_word_i, acc_wdata_i} <= {1'b1, w, a, k, d};
    @(posedge clock_i);
    chk(acc_ack_o, ack);
    acc_req_i <= 1'b0;
    #1 v = acc_rdata_o;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 64 && status_word_o[SW_DONE] !== 1'b1; i++) @(posedge clock_i);
    if (i == 64) begin
      fail_count++;
      results();
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic s_reset;
    tick(1);
    chk({status_word_o, wr_addr_o, host_halt_o}, '0);
    chk(acc_rdata_o, 16'h0000);
  endtask
  task automatic s_default;
    btc_mmb_t m;
    m = 19'h5A5A3;
    bus_u.mmb_set(m);
    go(16'h0001);
    bus_u.cycle(24'h00A5C3, 16'h1234, 1'b0, 1'b0);
    bus_u.cycle(24'hF0F00F, 16'hBEE5, 1'b1, 1'b1);
    bus_u.cycle(24'h123456, 16'h0F0F, 1'b0, 1'b1);
    tick(2);
    chk(wr_addr_o, 12'h003);
    acc(1'b0, 12'h001, 3'h0, 16'h0000, 1'b0);
    stop_run;
    ex = {3'h0, m[18:14], 2'b11, m[13:0], 24'hF0F00F, 16'hBEE5};
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, 12'h001, 3'(k), 16'h0000, 1'b1);
      chk(v, ex[16*k+:16]);
    end
    acc(1'b0, 12'h001, 3'h4, 16'h0000, 1'b1);
    chk(v, 16'h0000);
    acc(1'b0, 12'h001, 3'h5, 16'h0000, 1'b1);
    chk(v, 16'h0000);
    acc(1'b1, 12'h002, 3'h2, 16'hC3A5, 1'b1);
    acc(1'b0, 12'h002, 3'h2, 16'h0000, 1'b1);
    chk(v, 16'hC3A5);
  endtask
  task automatic s_qual;
    @(posedge clock_i);
    qc[0].care.data        <= 16'hFFFF;
    qc[0].value.data       <= 16'h1234;
    qc[1].logical_mode     <= 1'b1;
    qc[1].care.phys_addr   <= 24'hFFFFFF;
    qc[1].value.phys_addr  <= 24'h000001;
    go(16'h0101);
    bus_u.cycle(24'h000002, 16'h1111, 1'b0, 1'b0);
    bus_u.cycle(24'h000002, 16'h1234, 1'b0, 1'b0);
    tick(2);
    chk(wr_addr_o, 12'h001);
    stop_run;
    // Logical mode ignores the physical address, so this one admits all
    go(16'h0301);
    bus_u.cycle(24'h000002, 16'h1111, 1'b0, 1'b0);
    tick(2);
    chk(wr_addr_o, 12'h001);
    stop_run;
  endtask
  task automatic s_trig;
    @(posedge clock_i);
    tc[0].care.data  <= 16'hFFFF;
    tc[0].value.data <= 16'hBEEF;
    post_count_i     <= 12'h000;
    go(16'h100B);
    bus_u.cycle(24'h000005, 16'h1111, 1'b0, 1'b0);
    bus_u.cycle(24'h000006, 16'hBEEF, 1'b1, 1'b0);
    tick(2);
    chk(wr_addr_o, 12'h001);
    chk({status_word_o[SW_TRIG], status_word_o[SW_DONE]}, 2'b11);
    chk({host_halt_o, status_word_o[SW_HALT]}, 2'b11);
    post_count_i <= 12'h002;
    go(16'h1001);
    tick(1);
    chk(host_halt_o, 1'b0);
    for (int k = 0; k < 5; k++) bus_u.cycle(24'h000007, (k == 1) ? 16'hBEEF : 16'h2222,
                                            1'b0, 1'b0);
    tick(2);
    chk({wr_addr_o, status_word_o[SW_DONE]}, {12'h004, 1'b1});
  endtask
  task automatic s_seq;
    post_count_i <= 12'h000;
    go(16'h1051);
    bus_u.cycle(24'h000008, 16'hBEEF, 1'b0, 1'b0);
    bus_u.cycle(24'h000008, 16'h1111, 1'b0, 1'b0);
    bus_u.cycle(24'h000008, 16'hBEEF, 1'b0, 1'b0);
    tick(2);
    chk(status_word_o[SW_TRIG], 1'b0);
    bus_u.cycle(24'h000008, 16'hBEEF, 1'b0, 1'b0);
    tick(2);
    chk(status_word_o[SW_TRIG], 1'b1);
  endtask
  task automatic s_host;
    host_stopped_i <= 1'b1;
    go(16'h0005);
    tick(1);
    wait_done;
    chk(status_word_o[SW_TRIG], 1'b1);
    host_stopped_i <= 1'b0;
  endtask
  task automatic s_wrap;
    go(16'h0001);
    repeat (DEPTH) bus_u.cycle(24'h00000A, 16'h3333, 1'b0, 1'b0);
    tick(2);
    chk({wr_addr_o, status_word_o[SW_WRAP]}, {12'h000, 1'b1});
    stop_run;
  endtask

  initial begin
    {fail_count, compares} = '0;
    {rst_i, start_i, abort_i, host_stopped_i, acc_req_i, acc_write_i} = 6'h20;
    {ctrl_word_i, acc_wdata_i, post_count_i, acc_addr_i, acc_word_i} = '0;
    for (int k = 0; k < NCOND; k++) {qc[k], tc[k]} = '0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    s_reset;
    s_default;
    s_qual;
    s_trig;
    s_seq;
    s_host;
    s_wrap;
    results;
  end
endmodule // tb_bus_trace_capture

`default_nettype wire
